/* File: design/psna_pkg.sv */
// package: constants and carriers for the program sequencer next-address block
package psna_pkg;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 16;
	localparam int COND_W = 4;
	localparam int NIRQ = 4;
	localparam int ARITHMETIC_FLAGS_W = 8;
	localparam int MODE_FLAGS_W = 4;
	localparam int PC_DEPTH = 16;
	localparam int CNT_DEPTH = 4;
	localparam int STS_DEPTH = 4;
	localparam int LOOP_DEPTH = 4;
	localparam logic [ADDR_W-1:0] PC_RESET = 14'h0000;
	localparam logic [ADDR_W-1:0] VECTOR_BASE = 14'h0000;
	localparam logic [ADDR_W-1:0] ADDR_ONE = 14'h0001;
	localparam logic [DATA_W-1:0] COUNT_ONE = 16'h0001;
	localparam logic [COND_W-1:0] COND_CE = 4'hE;

	typedef enum logic [6:0] {
		PSNA_OP_NEXT = 7'h01,
		PSNA_OP_JUMP = 7'h02,
		PSNA_OP_CALL = 7'h04,
		PSNA_OP_RTS = 7'h08,
		PSNA_OP_RTI = 7'h10,
		PSNA_OP_DO = 7'h20,
		PSNA_OP_INDIRECT = 7'h40
	} psna_op_t;

	typedef struct packed {
		psna_op_t op;
		logic cond_true;
		logic [ADDR_W-1:0] target;
		logic [COND_W-1:0] term_cond;
		logic load_count;
	} psna_instr_t;

	typedef struct packed {
		logic [ARITHMETIC_FLAGS_W-1:0] arithmetic_flags;
		logic [MODE_FLAGS_W-1:0] mode_flags;
		logic [NIRQ-1:0] interrupt_enable_mask;
	} psna_status_t;

	typedef struct packed {
		logic [ADDR_W-1:0] end_addr;
		logic [COND_W-1:0] cond;
	} psna_loop_t;
endpackage : psna_pkg

/* File: design/psna_sequencer.sv */
// next-address selection and sequencer stacks
`timescale 1ns/10ps

// Overview of operation
// - linear flow increments pc, drives it on the address bus, reloads pc.
// - jump routes the 14-bit instruction target to the bus and pc.
// - call fetches the target and pushes pc plus one on the return stack.
// - subroutine return pops the return stack into pc.
// - taken interrupt aborts the fetch; only mask-enabled requests are taken.
// - interrupt entry pushes arithmetic, mode and mask flags on status stack.
// - interrupt entry pushes the unincremented pc on the return stack.
// - interrupt drives the vector of the serviced level onto bus and pc.
// - interrupt return pops return and status stacks, refetching aborted instruction.
// - counter load takes the new count from the data memory data bus.
// - counter load pushes the old count unless the counter is empty.
// - loop setup does no computation, executes once at loop entry.
// - loop setup pushes pc plus one, the loop start, on return stack.
// - same cycle, loop end address and condition are pushed on loop stack.
// - comparator checks fetch address against loop-stack end; linear until match.
// - match with false condition loops back to return stack top.
// - loop-back only reads return and loop stacks, no pops.
// - match with true condition pops return stack and continues at pc plus one.
// - loop exit also pops loop stack and count stack.
// - counter-expired comes from counter logic, other conditions from status logic.
// - indirect jump takes the second address generator value onto bus and pc.
// - request levels 0 to 3 vector to addresses 0000 to 0003.
// - highest unmasked level wins, level 3 highest.
// - aborted instruction on interrupt entry updates no data register.
// - taken transfer on loop last instruction suppresses all end-of-loop actions.
module psna_sequencer import psna_pkg::*; #(
	parameter int PC_D = PC_DEPTH,
	parameter int CNT_D = CNT_DEPTH,
	parameter int STS_D = STS_DEPTH,
	parameter int LOOP_D = LOOP_DEPTH
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic srst_i,
	// instruction and operands
	input wire psna_instr_t instr_i,
	input wire logic [DATA_W-1:0] data_memory_data_bus_i,
	input wire logic [ADDR_W-1:0] second_address_generator_i,
	input wire logic status_cond_i,
	// interrupts and status
	input wire logic [NIRQ-1:0] irq_i,
	input wire psna_status_t status_i,
	// outputs
	output logic [ADDR_W-1:0] program_address_bus_o,
	output logic abort_o,
	output logic [NIRQ-1:0] irq_ack_o,
	output logic status_restore_o,
	output psna_status_t status_pop_o,
	output logic counter_expired_o,
	output logic [DATA_W-1:0] count_o
);
	typedef struct packed {
		logic [ADDR_W-1:0] pc;
		logic [PC_D-1:0][ADDR_W-1:0] pcs;
		logic [$clog2(PC_D+1)-1:0] pc_n;
		logic [STS_D-1:0] [$bits(psna_status_t)-1:0] sts;
		logic [$clog2(STS_D+1)-1:0] sts_n;
		logic [LOOP_D-1:0][$bits(psna_loop_t)-1:0] lps;
		logic [$clog2(LOOP_D+1)-1:0] lp_n;
		logic [CNT_D-1:0][DATA_W-1:0] cns;
		logic [$clog2(CNT_D+1)-1:0] cn_n;
		logic [DATA_W-1:0] count;
		logic count_valid;
		logic abort;
		logic [NIRQ-1:0] ack;
		logic restore;
		psna_status_t status_pop;
		logic [ADDR_W-1:0] program_address_bus;
	} psna_state_t;

	psna_state_t st;
	psna_state_t next_st;

	function automatic logic [NIRQ-1:0] prio_pick(input logic [NIRQ-1:0] req);
		logic [NIRQ-1:0] g;
		g = '0;
		for (int i = 0; i < NIRQ; i++) begin
			if (req[i]) begin
				g = '0;
				g[i] = 1'b1;
			end
		end
		return g;
	endfunction : prio_pick

	function automatic logic [ADDR_W-1:0] vec_of(input logic [NIRQ-1:0] g);
		logic [ADDR_W-1:0] v;
		v = VECTOR_BASE;
		for (int i = 0; i < NIRQ; i++) begin
			if (g[i]) begin
				v = VECTOR_BASE + ADDR_W'(i);
			end
		end
		return v;
	endfunction : vec_of

	// next-address mux source select
	typedef enum logic [4:0] {
		PSNA_SRC_INC = 5'h01,
		PSNA_SRC_INSTR = 5'h02,
		PSNA_SRC_VECTOR = 5'h04,
		PSNA_SRC_STACK = 5'h08,
		PSNA_SRC_DAG = 5'h10
	} psna_src_t;

	function automatic logic is_transfer(input psna_instr_t ins);
		logic t;
		t = 1'b0;
		if (ins.cond_true) begin
			unique case (ins.op)
				PSNA_OP_JUMP, PSNA_OP_CALL, PSNA_OP_RTS, PSNA_OP_RTI, PSNA_OP_INDIRECT: begin
					t = 1'b1;
				end
				PSNA_OP_NEXT, PSNA_OP_DO: begin
					t = 1'b0;
				end
			endcase
		end
		return t;
	endfunction : is_transfer

	function automatic logic cond_is_ce(input logic [COND_W-1:0] c);
		return c == COND_CE;
	endfunction : cond_is_ce

	logic [NIRQ-1:0] grant;
	logic take_irq;
	logic [ADDR_W-1:0] pc_inc;
	logic [ADDR_W-1:0] pc_top;
	psna_loop_t loop_top;
	logic in_loop;
	logic at_end;
	logic term_true;
	logic transfer;
	logic expired;
	logic pc_room;
	logic pc_any;
	logic sts_room;
	logic sts_any;
	logic lp_room;
	logic cn_room;
	logic cn_any;
	psna_src_t src;

	always_comb begin
		grant = prio_pick(irq_i & status_i.interrupt_enable_mask);
		take_irq = |grant;
		pc_inc = st.pc + ADDR_ONE;

		// stack occupancy
		pc_room = (st.pc_n < PC_D[$bits(st.pc_n)-1:0]);
		pc_any = (st.pc_n != '0);
		pc_top = pc_any ? st.pcs[st.pc_n - 1'b1] : pc_inc;
		sts_room = (st.sts_n < STS_D[$bits(st.sts_n)-1:0]);
		sts_any = (st.sts_n != '0);
		lp_room = (st.lp_n < LOOP_D[$bits(st.lp_n)-1:0]);
		cn_room = (st.cn_n < CNT_D[$bits(st.cn_n)-1:0]);
		cn_any = (st.cn_n != '0);

		// loop comparator and termination
		in_loop = (st.lp_n != '0);
		loop_top = in_loop ? psna_loop_t'(st.lps[st.lp_n - 1'b1]) : '0;
		at_end = in_loop && (st.pc == loop_top.end_addr);
		expired = st.count_valid && (st.count == COUNT_ONE);
		term_true = cond_is_ce(loop_top.cond) ? expired : status_cond_i;
		transfer = is_transfer(instr_i);

		src = PSNA_SRC_INC;
		next_st = st;
		next_st.abort = 1'b0;
		next_st.ack = '0;
		next_st.restore = 1'b0;
		if (take_irq) begin
			// aborted instruction has no effect; data path sees abort_o
			next_st.abort = 1'b1;
			next_st.ack = grant;
			src = PSNA_SRC_VECTOR;
			if (pc_room) begin
				next_st.pcs[st.pc_n] = st.pc;
				next_st.pc_n = st.pc_n + 1'b1;
			end
			if (sts_room) begin
				next_st.sts[st.sts_n] = status_i;
				next_st.sts_n = st.sts_n + 1'b1;
			end
		end else begin
			if (instr_i.load_count) begin
				if (st.count_valid && cn_room) begin
					next_st.cns[st.cn_n] = st.count;
					next_st.cn_n = st.cn_n + 1'b1;
				end
				next_st.count = data_memory_data_bus_i;
				next_st.count_valid = 1'b1;
			end
			if (transfer) begin
				unique case (instr_i.op)
					PSNA_OP_JUMP: begin
						src = PSNA_SRC_INSTR;
					end
					PSNA_OP_INDIRECT: begin
						src = PSNA_SRC_DAG;
					end
					PSNA_OP_CALL: begin
						src = PSNA_SRC_INSTR;
						if (pc_room) begin
							next_st.pcs[st.pc_n] = pc_inc;
							next_st.pc_n = st.pc_n + 1'b1;
						end
					end
					PSNA_OP_RTS, PSNA_OP_RTI: begin
						if (pc_any) begin
							src = PSNA_SRC_STACK;
							next_st.pc_n = st.pc_n - 1'b1;
						end
						if (instr_i.op == PSNA_OP_RTI && sts_any) begin
							next_st.status_pop = psna_status_t'(st.sts[st.sts_n - 1'b1]);
							next_st.restore = 1'b1;
							next_st.sts_n = st.sts_n - 1'b1;
						end
					end
					default: begin
						src = PSNA_SRC_INC;
					end
				endcase
			end else begin
				if (instr_i.op == PSNA_OP_DO) begin
					// setup only, no computation
					if (pc_room) begin
						next_st.pcs[st.pc_n] = pc_inc;
						next_st.pc_n = st.pc_n + 1'b1;
					end
					if (lp_room) begin
						next_st.lps[st.lp_n] = {instr_i.target, instr_i.term_cond};
						next_st.lp_n = st.lp_n + 1'b1;
					end
				end
				if (at_end) begin
					if (cond_is_ce(loop_top.cond) && !instr_i.load_count && st.count_valid) begin
						next_st.count = st.count - COUNT_ONE;
					end
					if (!term_true) begin
						if (pc_any) begin
							src = PSNA_SRC_STACK;
						end
					end else begin
						src = PSNA_SRC_INC;
						if (pc_any) begin
							next_st.pc_n = st.pc_n - 1'b1;
						end
						next_st.lp_n = st.lp_n - 1'b1;
						if (cn_any) begin
							next_st.count = st.cns[st.cn_n - 1'b1];
							next_st.cn_n = st.cn_n - 1'b1;
						end else begin
							next_st.count_valid = 1'b0;
						end
					end
				end
			end
		end

		// next-address mux
		unique case (src)
			PSNA_SRC_INC: begin
				next_st.program_address_bus = pc_inc;
			end
			PSNA_SRC_INSTR: begin
				next_st.program_address_bus = instr_i.target;
			end
			PSNA_SRC_VECTOR: begin
				next_st.program_address_bus = vec_of(grant);
			end
			PSNA_SRC_STACK: begin
				next_st.program_address_bus = pc_top;
			end
			PSNA_SRC_DAG: begin
				next_st.program_address_bus = second_address_generator_i;
			end
		endcase
		next_st.pc = next_st.program_address_bus;
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			st <= '0;
			st.pc <= PC_RESET;
			st.program_address_bus <= PC_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign program_address_bus_o = st.program_address_bus;
	assign abort_o = st.abort;
	assign irq_ack_o = st.ack;
	assign status_restore_o = st.restore;
	assign status_pop_o = st.status_pop;
	assign counter_expired_o = st.count_valid && (st.count == COUNT_ONE);
	assign count_o = st.count;
endmodule : psna_sequencer

/* File: verif/psna_program_memory.sv */
// program memory model on the address bus
`timescale 1ns/10ps
module psna_program_memory import psna_pkg::*; (
	// fetch port
	input wire logic [ADDR_W-1:0] addr_i,
	output psna_instr_t instr_o
);
	psna_instr_t mem [0:63];
	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = '{op: PSNA_OP_NEXT, default: '0};
		end
	end
	assign #1 instr_o = mem[addr_i[5:0]];
endmodule : psna_program_memory

/* File: verif/psna_sequencer_asserts.sv */
// checker for the sequencer ports
`timescale 1ns/10ps
module psna_sequencer_asserts import psna_pkg::*; (
	// watched ports
	input wire logic clock_i,
	input wire logic srst_i,
	input wire psna_instr_t instr_i,
	input wire logic [DATA_W-1:0] data_memory_data_bus_i,
	input wire logic [ADDR_W-1:0] second_address_generator_i,
	input wire logic [NIRQ-1:0] irq_i,
	input wire psna_status_t status_i,
	input wire logic [ADDR_W-1:0] program_address_bus_o,
	input wire logic abort_o,
	input wire logic [NIRQ-1:0] irq_ack_o,
	input wire logic status_restore_o,
	input wire logic counter_expired_o,
	input wire logic [DATA_W-1:0] count_o
);
	wire logic [NIRQ-1:0] m = irq_i & status_i.interrupt_enable_mask;
	wire logic go = instr_i.cond_true && m == 4'h0;
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	a_irq_vector: assert property (m != 4'h0 |=> abort_o &&
		program_address_bus_o[13:2] == 12'h000 && irq_ack_o[program_address_bus_o[1:0]]) else $error("vector");
	a_irq_prio: assert property (m[3] |=> irq_ack_o == 4'h8) else $error("priority");
	a_mask_gate: assert property (m == 4'h0 |=> !abort_o && irq_ack_o == 4'h0) else $error("mask");
	a_jump_target: assert property (go && instr_i.op inside {PSNA_OP_JUMP, PSNA_OP_CALL}
		|=> program_address_bus_o == $past(instr_i.target)) else $error("jump");
	a_indirect_jump: assert property (go && instr_i.op == PSNA_OP_INDIRECT
		|=> program_address_bus_o == $past(second_address_generator_i)) else $error("indirect");
	a_rti_restore: assert property (status_restore_o |-> $past(instr_i.op) == PSNA_OP_RTI) else $error("restore");
	a_count_load: assert property (instr_i.load_count && m == 4'h0
		|=> count_o == $past(data_memory_data_bus_i)) else $error("count");
	a_expired_one: assert property (counter_expired_o |-> count_o == COUNT_ONE) else $error("expired");
	c_irq: cover property (abort_o);
	c_ret: cover property (status_restore_o);
	c_exp: cover property (counter_expired_o);
endmodule : psna_sequencer_asserts
bind psna_sequencer psna_sequencer_asserts u_chk (
	.clock_i(clock_i),
	.srst_i(srst_i),
	.instr_i(instr_i),
	.data_memory_data_bus_i(data_memory_data_bus_i),
	.second_address_generator_i(second_address_generator_i),
	.irq_i(irq_i),
	.status_i(status_i),
	.program_address_bus_o(program_address_bus_o),
	.abort_o(abort_o),
	.irq_ack_o(irq_ack_o),
	.status_restore_o(status_restore_o),
	.counter_expired_o(counter_expired_o),
	.count_o(count_o)
);

/* File: verif/test_psna_sequencer.sv */
// testbench for the sequencer next-address flows
`timescale 1ns/10ps
module test_psna_sequencer import psna_pkg::*; ;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	psna_instr_t instr_i;
	logic [DATA_W-1:0] data_memory_data_bus_i = 16'h0002;
	logic [ADDR_W-1:0] second_address_generator_i = 14'h0005;
	logic status_cond_i = 1'b0;
	logic [NIRQ-1:0] irq_i = 4'h0;
	psna_status_t status_i = '0;
	logic [ADDR_W-1:0] program_address_bus_o;
	logic abort_o, status_restore_o, counter_expired_o;
	logic [NIRQ-1:0] irq_ack_o;
	psna_status_t status_pop_o;
	logic [DATA_W-1:0] count_o;
	int fail_count = 0;
	int tests_run = 0;
	int cycles = 0;
	initial begin
		forever #2.5 clock_i = ~clock_i;
	end
	psna_sequencer uut (
		.clock_i(clock_i),
		.srst_i(srst_i),
		.instr_i(instr_i),
		.data_memory_data_bus_i(data_memory_data_bus_i),
		.second_address_generator_i(second_address_generator_i),
		.status_cond_i(status_cond_i),
		.irq_i(irq_i),
		.status_i(status_i),
		.program_address_bus_o(program_address_bus_o),
		.abort_o(abort_o),
		.irq_ack_o(irq_ack_o),
		.status_restore_o(status_restore_o),
		.status_pop_o(status_pop_o),
		.counter_expired_o(counter_expired_o),
		.count_o(count_o)
	);
	psna_program_memory pmem (.addr_i(program_address_bus_o), .instr_o(instr_i));
	function automatic psna_instr_t ins(psna_op_t op, logic [13:0] t, logic [3:0] c);
		return '{op, 1'b1, t, c, 1'b0};
	endfunction : ins
	task automatic check(string n, logic [15:0] s, logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic step(logic [13:0] e);
		@(posedge clock_i);
		#1;
		check("bus", {2'b00, program_address_bus_o}, {2'b00, e});
	endtask : step
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic t_flow();
		step(14'h0001);
		check("count", count_o, 16'h0002);
		step(14'h0008);
		step(14'h0002);
		step(14'h0005);
		step(14'h000C);
	endtask : t_flow
	task automatic t_loop();
		step(14'h000D);
		step(14'h000E);
		step(14'h000D);
		check("count", count_o, 16'h0001);
		check("expired", counter_expired_o, 16'h0001);
		step(14'h000E);
		step(14'h000F);
	endtask : t_loop
	task automatic t_irq();
		status_i = '{8'h5A, 4'h3, 4'hB};
		irq_i = 4'h4;
		step(14'h0010);
		irq_i = 4'hB;
		step(14'h0003);
		check("abort", abort_o, 16'h0001);
		check("ack", irq_ack_o, 16'h0008);
		irq_i = 4'h0;
		status_i = '0;
		step(14'h0010);
		check("restore", status_restore_o, 16'h0001);
		check("popped", status_pop_o, 16'h5A3B);
	endtask : t_irq
	task automatic t_cond();
		step(14'h0011);
		step(14'h0011);
		status_cond_i = 1'b1;
		step(14'h0012);
		status_cond_i = 1'b0;
		step(14'h0013);
		step(14'h0016);
	endtask : t_cond
	initial begin
		#1;
		pmem.mem[0] = '{PSNA_OP_NEXT, 1'b1, 14'h0000, 4'h0, 1'b1};
		pmem.mem[1] = ins(PSNA_OP_CALL, 14'h0008, 4'h0);
		pmem.mem[8] = ins(PSNA_OP_RTS, 14'h0000, 4'h0);
		pmem.mem[2] = ins(PSNA_OP_INDIRECT, 14'h0000, 4'h0);
		pmem.mem[5] = ins(PSNA_OP_JUMP, 14'h000C, 4'h0);
		pmem.mem[12] = ins(PSNA_OP_DO, 14'h000E, COND_CE);
		pmem.mem[3] = ins(PSNA_OP_RTI, 14'h0000, 4'h0);
		pmem.mem[16] = ins(PSNA_OP_DO, 14'h0011, 4'h0);
		pmem.mem[18] = ins(PSNA_OP_DO, 14'h0013, 4'h0);
		pmem.mem[19] = ins(PSNA_OP_JUMP, 14'h0016, 4'h0);
		repeat (4) @(posedge clock_i);
		#1;
		srst_i = 1'b0;
		t_flow();
		t_loop();
		t_irq();
		t_cond();
		print_verdict();
	end
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 500) begin
			fail_count++;
			print_verdict();
		end
	end
endmodule : test_psna_sequencer
